// [src/dic_regs.vh]
// Purpose: constants for the dual input counter and capture block
// Assumes: word registers and bit registers are addressed by their printed offsets
// Notes: plain header, definitions only
`ifndef DIC_REGS_VH
`define DIC_REGS_VH

// ---------------------------------------------
// word register offsets
// ---------------------------------------------
`define DIC_CNT1_LO 16'h0036
`define DIC_CNT1_HI 16'h0037
`define DIC_CNT2_LO 16'h0038
`define DIC_CNT2_HI 16'h0039
`define DIC_HELD1_LO 16'h003C
`define DIC_HELD1_HI 16'h003D
`define DIC_HELD2_LO 16'h003E
`define DIC_HELD2_HI 16'h003F
`define DIC_SETUP1 16'h0044
`define DIC_SETUP2 16'h0045
`define DIC_CATCH 16'h0048
`define DIC_DONE 16'h0049

// ---------------------------------------------
// bit register offsets
// ---------------------------------------------
`define DIC_REQ_BIT1 16'h0480
`define DIC_REQ_BIT2 16'h0481
`define DIC_DONE_BIT1 16'h0490
`define DIC_DONE_BIT2 16'h0491

// ---------------------------------------------
// configuration field positions
// ---------------------------------------------
`define DIC_CFG_TIME 0
`define DIC_CFG_AUTO 1
`define DIC_CFG_CATCH_LOW 2
`define DIC_CFG_CLR_AFTER 3
`define DIC_CFG_ZERO_LOW 4
`define DIC_CFG_ENCODER 5

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define DIC_RST_WORD 16'h0000
`define DIC_RST_COUNT 32'h00000000

// ---------------------------------------------
// timing
// ---------------------------------------------
`define DIC_CLK_KHZ 50000
`define DIC_AUTO_PERIOD_MS 1000
`define DIC_TIME_UNIT_MS 1
`define DIC_AUTO_CYCLES (`DIC_AUTO_PERIOD_MS * `DIC_CLK_KHZ)
`define DIC_UNIT_CYCLES (`DIC_TIME_UNIT_MS * `DIC_CLK_KHZ)

`endif

// [src/dic_tick.v]
// Purpose: free running divider that makes one-cycle tick pulses
// Assumes: mclk runs continuously
// Notes: tick is high for one cycle every PERIOD cycles
`timescale 1ns/1ps
module dic_tick #(
   parameter PERIOD = 50000
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // tick out
   output reg tick
);
   reg [31:0] countReg;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         countReg <= 32'h00000000;
         tick <= 1'b0;
      end else if (countReg >= PERIOD - 1) begin
         countReg <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         countReg <= countReg + 32'h00000001;
         tick <= 1'b0;
      end
   end
endmodule // dic_tick

// [src/dic_counter_capture.v]
// Purpose: two 32-bit counters with capture registers, reached as 16-bit words and bits
// Assumes: fieldIn pins are synchronous to mclk; one access at a time from the word/bit port
// Notes: read data appears one cycle after the read strobe, with a valid pulse
`timescale 1ns/1ps
`include "dic_regs.vh"
module dic_counter_capture #(
   parameter AUTO_CYCLES = `DIC_AUTO_CYCLES,
   parameter UNIT_CYCLES = `DIC_UNIT_CYCLES
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // field inputs
   input wire [1:0] fieldIn,
   // word register port
   input wire wordWrite,
   input wire wordRead,
   input wire [15:0] wordAddr,
   input wire [15:0] wordWrData,
   output reg [15:0] wordRdData,
   output reg wordRdValid,
   // bit register port
   input wire bitWrite,
   input wire bitRead,
   input wire [15:0] bitAddr,
   input wire bitWrData,
   output reg bitRdData,
   output reg bitRdValid,
   // status
   output reg [1:0] captureDone
);

   // ---------------------------------------------
   // storage
   // ---------------------------------------------
   reg [31:0] count_reg [0:1];
   reg [31:0] count_next [0:1];
   reg [31:0] held_reg [0:1];
   reg [31:0] held_next [0:1];
   reg [15:0] setup_reg [0:1];
   reg [1:0] done_next;
   reg [1:0] inPrev_reg;
   reg [1:0] swReq;
   reg [1:0] capture;
   wire secTick;
   wire unitTick;
   integer c;
   integer r;

   // ---------------------------------------------
   // timebases
   // ---------------------------------------------
   dic_tick #(
      .PERIOD(AUTO_CYCLES)
   ) secGen (
      .mclk(mclk),
      .reset_n(reset_n),
      .tick(secTick)
   );

   dic_tick #(
      .PERIOD(UNIT_CYCLES)
   ) unitGen (
      .mclk(mclk),
      .reset_n(reset_n),
      .tick(unitTick)
   );

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // word write hit on a given offset; strobe and address passed in so always @* sees them
   function wordHit;
      input strobe;
      input [15:0] addr;
      input [15:0] off;
      begin
         wordHit = strobe && (addr == off);
      end
   endfunction

   // bit write hit on a given offset; strobe and address passed in so always @* sees them
   function bitHit;
      input strobe;
      input [15:0] addr;
      input [15:0] off;
      begin
         bitHit = strobe && (addr == off);
      end
   endfunction

   // replace one half of a 32-bit value
   function [31:0] putHalf;
      input [31:0] old;
      input hi;
      input [15:0] val;
      begin
         putHalf = hi ? {val, old[15:0]} : {old[31:16], val};
      end
   endfunction

   // ---------------------------------------------
   // software capture requests
   // ---------------------------------------------
   always @* begin
      swReq[0] = (wordHit(wordWrite, wordAddr, `DIC_CATCH) && wordWrData[0]) ||
                 (bitHit(bitWrite, bitAddr, `DIC_REQ_BIT1) && bitWrData);
      swReq[1] = (wordHit(wordWrite, wordAddr, `DIC_CATCH) && wordWrData[1]) ||
                 (bitHit(bitWrite, bitAddr, `DIC_REQ_BIT2) && bitWrData);
   end

   // ---------------------------------------------
   // per-channel next state
   // ---------------------------------------------
   always @* begin
      for (c = 0; c < 2; c = c + 1) begin
         capture[c] = swReq[c]
            || (setup_reg[c][`DIC_CFG_AUTO] && secTick)
            || (setup_reg[c][`DIC_CFG_CATCH_LOW] && !fieldIn[c]);
         count_next[c] = count_reg[c];
         held_next[c] = held_reg[c];
         // counting source
         if (setup_reg[c][`DIC_CFG_ENCODER]) begin
            // rising edge of own input, direction from the other input
            if (fieldIn[c] && !inPrev_reg[c]) begin
               if (fieldIn[1 - c])
                  count_next[c] = count_reg[c] - 32'h00000001;
               else
                  count_next[c] = count_reg[c] + 32'h00000001;
            end
         end else if (setup_reg[c][`DIC_CFG_TIME]) begin
            // time spent high, in time units
            if (fieldIn[c] && unitTick)
               count_next[c] = count_reg[c] + 32'h00000001;
         end else begin
            if (fieldIn[c] && !inPrev_reg[c])
               count_next[c] = count_reg[c] + 32'h00000001;
         end
         // capture takes the count before this cycle's increment
         if (capture[c]) begin
            held_next[c] = count_reg[c];
            if (setup_reg[c][`DIC_CFG_CLR_AFTER])
               count_next[c] = `DIC_RST_COUNT;
         end
         if (setup_reg[c][`DIC_CFG_ZERO_LOW] && !fieldIn[c])
            count_next[c] = `DIC_RST_COUNT;
      end
      // software presets win over counting
      if (wordHit(wordWrite, wordAddr, `DIC_CNT1_LO) ||
          wordHit(wordWrite, wordAddr, `DIC_CNT1_HI))
         count_next[0] = putHalf(count_reg[0], wordAddr[0], wordWrData);
      if (wordHit(wordWrite, wordAddr, `DIC_CNT2_LO) ||
          wordHit(wordWrite, wordAddr, `DIC_CNT2_HI))
         count_next[1] = putHalf(count_reg[1], wordAddr[0], wordWrData);
      if (wordHit(wordWrite, wordAddr, `DIC_HELD1_LO) ||
          wordHit(wordWrite, wordAddr, `DIC_HELD1_HI))
         held_next[0] = putHalf(held_reg[0], wordAddr[0], wordWrData);
      if (wordHit(wordWrite, wordAddr, `DIC_HELD2_LO) ||
          wordHit(wordWrite, wordAddr, `DIC_HELD2_HI))
         held_next[1] = putHalf(held_reg[1], wordAddr[0], wordWrData);
   end

   // ---------------------------------------------
   // captured flags: a capture wins over a clear
   // ---------------------------------------------
   always @* begin
      done_next = captureDone;
      if (wordHit(wordWrite, wordAddr, `DIC_DONE))
         done_next = wordWrData[1:0];
      if (bitHit(bitWrite, bitAddr, `DIC_DONE_BIT1))
         done_next[0] = bitWrData;
      if (bitHit(bitWrite, bitAddr, `DIC_DONE_BIT2))
         done_next[1] = bitWrData;
      done_next = done_next | capture;
   end

   // ---------------------------------------------
   // state registers
   // ---------------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (r = 0; r < 2; r = r + 1) begin
            count_reg[r] <= `DIC_RST_COUNT;
            held_reg[r] <= `DIC_RST_COUNT;
            setup_reg[r] <= `DIC_RST_WORD;
         end
         inPrev_reg <= 2'h0;
         captureDone <= 2'h0;
      end else begin
         for (r = 0; r < 2; r = r + 1) begin
            count_reg[r] <= count_next[r];
            held_reg[r] <= held_next[r];
         end
         if (wordHit(wordWrite, wordAddr, `DIC_SETUP1))
            setup_reg[0] <= wordWrData;
         if (wordHit(wordWrite, wordAddr, `DIC_SETUP2))
            setup_reg[1] <= wordWrData;
         inPrev_reg <= fieldIn;
         captureDone <= done_next;
      end
   end

   // ---------------------------------------------
   // word read-back
   // ---------------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wordRdData <= `DIC_RST_WORD;
         wordRdValid <= 1'b0;
      end else begin
         wordRdValid <= wordRead;
         if (wordRead) begin
            case (wordAddr)
               `DIC_CNT1_LO: wordRdData <= count_reg[0][15:0];
               `DIC_CNT1_HI: wordRdData <= count_reg[0][31:16];
               `DIC_CNT2_LO: wordRdData <= count_reg[1][15:0];
               `DIC_CNT2_HI: wordRdData <= count_reg[1][31:16];
               `DIC_HELD1_LO: wordRdData <= held_reg[0][15:0];
               `DIC_HELD1_HI: wordRdData <= held_reg[0][31:16];
               `DIC_HELD2_LO: wordRdData <= held_reg[1][15:0];
               `DIC_HELD2_HI: wordRdData <= held_reg[1][31:16];
               `DIC_SETUP1: wordRdData <= setup_reg[0];
               `DIC_SETUP2: wordRdData <= setup_reg[1];
               `DIC_DONE: wordRdData <= {14'h0000, captureDone};
               // catch requests self-clear, so they read as zero
               default: wordRdData <= `DIC_RST_WORD;
            endcase
         end
      end
   end

   // ---------------------------------------------
   // bit read-back
   // ---------------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bitRdData <= 1'b0;
         bitRdValid <= 1'b0;
      end else begin
         bitRdValid <= bitRead;
         if (bitRead) begin
            case (bitAddr)
               `DIC_DONE_BIT1: bitRdData <= captureDone[0];
               `DIC_DONE_BIT2: bitRdData <= captureDone[1];
               default: bitRdData <= 1'b0;
            endcase
         end
      end
   end
endmodule // dic_counter_capture

// [testbench/dic_counter_capture_assertions.sv]
// Purpose: port checks for the counter capture block
// Assumes: one clock, async active-low reset
// Notes: bound to the design after the module
`timescale 1ns/1ps
`include "dic_regs.vh"
module dic_counter_capture_assertions (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // word port
   input wire wordWrite,
   input wire wordRead,
   input wire [15:0] wordAddr,
   input wire [15:0] wordWrData,
   input wire [15:0] wordRdData,
   input wire wordRdValid,
   // bit port and status
   input wire bitWrite,
   input wire bitRead,
   input wire [15:0] bitAddr,
   input wire bitWrData,
   input wire bitRdData,
   input wire bitRdValid,
   input wire [1:0] captureDone
);
   // ---------------
   // checks
   // ---------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire clrOne = (wordWrite && wordAddr == `DIC_DONE) || (bitWrite && bitAddr == `DIC_DONE_BIT1);
   sequence catchWordOne;
      wordWrite && wordAddr == `DIC_CATCH && wordWrData[0];
   endsequence
   sequence catchBitTwo;
      bitWrite && bitAddr == `DIC_REQ_BIT2 && bitWrData;
   endsequence
   sequence readCatch;
      wordRead && wordAddr == `DIC_CATCH ##1 wordRdValid;
   endsequence
   AST_WORD_VALID: assert property (wordRead |=> wordRdValid) else $error("no valid");
   AST_NO_VALID: assert property (!wordRead |=> !wordRdValid) else $error("stray valid");
   AST_CATCH_ONE: assert property (catchWordOne |=> captureDone[0]) else $error("no flag");
   AST_CATCH_TWO: assert property (catchBitTwo |=> captureDone[1]) else $error("no flag");
   AST_CATCH_READ: assert property (readCatch |-> wordRdData == 16'h0000)
      else $error("catch word read not zero");
   AST_DONE_STANDS: assert property (captureDone[0] && !clrOne |=> captureDone[0])
      else $error("flag dropped");
   AST_DONE_READ: assert property (bitRead && bitAddr == `DIC_DONE_BIT1 |=>
      bitRdData == $past(captureDone[0])) else $error("flag read wrong");
   AST_BIT_VALID: assert property (bitRead |=> bitRdValid) else $error("no bit valid");
endmodule // dic_counter_capture_assertions
bind dic_counter_capture dic_counter_capture_assertions u_chk (.mclk(mclk), .reset_n(reset_n),
   .wordWrite(wordWrite), .wordRead(wordRead), .wordAddr(wordAddr), .wordWrData(wordWrData),
   .wordRdData(wordRdData), .wordRdValid(wordRdValid), .bitWrite(bitWrite), .bitRead(bitRead),
   .bitAddr(bitAddr), .bitWrData(bitWrData), .bitRdData(bitRdData), .bitRdValid(bitRdValid),
   .captureDone(captureDone));

// [testbench/dic_field_model.sv]
// Purpose: field input source for the counter capture bench
// Assumes: levels change at the falling clock edge
// Notes: a pulse is one cycle high, two low
`timescale 1ns/1ps
module dic_field_model (
   // clock
   input wire mclk,
   // field levels
   output logic [1:0] fieldIn
);
   initial begin
      fieldIn = 2'h0;
   end
   task automatic level(input int ch, input logic val);
      @(negedge mclk);
      fieldIn[ch] = val;
   endtask
   task automatic pulse(input int ch, input int n);
      repeat (n) begin
         level(ch, 1'b1);
         level(ch, 1'b0);
         @(negedge mclk);
      end
   endtask
endmodule // dic_field_model

// [testbench/test_dual_input_counter_capture.sv]
// Purpose: register-level test of the counter capture block
// Assumes: short auto and time periods set by parameter
// Notes: all inputs change at the falling edge
`timescale 1ns/1ps
`include "dic_regs.vh"
module test_dual_input_counter_capture;
   logic mclk;
   logic reset_n;
   logic wordWrite;
   logic wordRead;
   logic [15:0] wordAddr;
   logic [15:0] wordWrData;
   logic bitWrite;
   logic bitRead;
   logic [15:0] bitAddr;
   logic bitWrData;
   wire [15:0] wordRdData;
   wire wordRdValid;
   wire bitRdData;
   wire bitRdValid;
   wire [1:0] captureDone;
   wire [1:0] fieldIn;
   logic [16:0] v;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   dic_field_model u_field (.mclk(mclk), .fieldIn(fieldIn));
   dic_counter_capture #(.AUTO_CYCLES(100), .UNIT_CYCLES(10)) u_dut (.mclk(mclk),
      .reset_n(reset_n), .fieldIn(fieldIn), .wordWrite(wordWrite), .wordRead(wordRead),
      .wordAddr(wordAddr), .wordWrData(wordWrData), .wordRdData(wordRdData),
      .wordRdValid(wordRdValid), .bitWrite(bitWrite), .bitRead(bitRead), .bitAddr(bitAddr),
      .bitWrData(bitWrData), .bitRdData(bitRdData), .bitRdValid(bitRdValid),
      .captureDone(captureDone));
   // ---------------
   // helpers
   // ---------------
   task automatic finish_test;
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge mclk);
      wordWrite = 1;
      wordAddr = a;
      wordWrData = d;
      @(negedge mclk);
      wordWrite = 0;
   endtask
   task automatic bwr(input logic [15:0] a, input logic d);
      @(negedge mclk);
      bitWrite = 1;
      bitAddr = a;
      bitWrData = d;
      @(negedge mclk);
      bitWrite = 0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(negedge mclk);
      wordRead = 1;
      wordAddr = a;
      @(negedge mclk);
      wordRead = 0;
      // valid stands only in the cycle after the read edge
      v = {wordRdValid, wordRdData};
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
      rd(a);
      chk(v, {1'b1, e});
   endtask
   task automatic brdchk(input logic [15:0] a, input logic e);
      @(negedge mclk);
      bitRead = 1;
      bitAddr = a;
      @(negedge mclk);
      bitRead = 0;
      chk({bitRdValid, bitRdData}, {1'b1, e});
   endtask
   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         finish_test;
      end
   end
   // ---------------
   // tests
   // ---------------
   initial begin
      {reset_n, wordWrite, wordRead, bitWrite, bitRead, bitWrData} = 6'h00;
      wordAddr = 16'h0000;
      wordWrData = 16'h0000;
      bitAddr = 16'h0000;
      repeat (3) @(negedge mclk);
      reset_n = 1;
      rdchk(`DIC_SETUP1, 16'h0000);
      rdchk(16'h0040, 16'h0000);
      wr(`DIC_CNT1_LO, 16'h1234);
      wr(`DIC_CNT1_HI, 16'hABCD);
      rdchk(`DIC_CNT1_HI, 16'hABCD);
      wr(`DIC_CATCH, 16'h0001);
      rdchk(`DIC_HELD1_LO, 16'h1234);
      rdchk(`DIC_HELD1_HI, 16'hABCD);
      rdchk(`DIC_CATCH, 16'h0000);
      brdchk(`DIC_DONE_BIT1, 1'b1);
      wr(`DIC_DONE, 16'h0000);
      chk(captureDone, 2'h0);
      wr(`DIC_CNT2_LO, 16'h0000);
      u_field.pulse(1, 5);
      rdchk(`DIC_CNT2_LO, 16'h0005);
      wr(`DIC_SETUP2, 16'h0008);
      bwr(`DIC_REQ_BIT2, 1'b1);
      rdchk(`DIC_HELD2_LO, 16'h0005);
      rdchk(`DIC_CNT2_LO, 16'h0000);
      wr(`DIC_SETUP2, 16'h0020);
      u_field.pulse(1, 3);
      rdchk(`DIC_CNT2_LO, 16'h0003);
      u_field.level(0, 1'b1);
      u_field.pulse(1, 1);
      u_field.level(0, 1'b0);
      rdchk(`DIC_CNT2_LO, 16'h0002);
      wr(`DIC_SETUP1, 16'h0010);
      rdchk(`DIC_CNT1_LO, 16'h0000);
      wr(`DIC_SETUP1, 16'h0004);
      wr(`DIC_CNT1_LO, 16'h0009);
      wr(`DIC_DONE, 16'h0000);
      rdchk(`DIC_HELD1_LO, 16'h0009);
      chk(captureDone[0], 1'b1);
      wr(`DIC_SETUP1, 16'h0001);
      wr(`DIC_CNT1_LO, 16'h0000);
      wr(`DIC_SETUP2, 16'h0002);
      wr(`DIC_CNT2_LO, 16'h0055);
      u_field.level(0, 1'b1);
      repeat (100) @(negedge mclk);
      u_field.level(0, 1'b0);
      rd(`DIC_CNT1_LO);
      chk(v[16], 1'b1);
      chk(v[15:0] >= 16'h0009 && v[15:0] <= 16'h000B, 1'b1);
      rdchk(`DIC_HELD2_LO, 16'h0055);
      finish_test;
   end
endmodule // test_dual_input_counter_capture
